// ---- hdl/salal_pkg.sv ----
// Package: constants for the shared lobby arming coordinator
package salal_pkg;

    localparam int          PART_NUM      = 2;
    localparam int          PART_IDX_W    = 1;
    localparam int          SRC_W         = 3;
    localparam int          OP_W          = 2;

    // Request sources
    localparam logic [2:0]  SRC_KEYPAD    = 3'h0;
    localparam logic [2:0]  SRC_GLOBAL    = 3'h1;
    localparam logic [2:0]  SRC_QUICK     = 3'h2;
    localparam logic [2:0]  SRC_KEYSW     = 3'h3;
    localparam logic [2:0]  SRC_WLBTN     = 3'h4;
    localparam logic [2:0]  SRC_WLKPD     = 3'h5;
    localparam logic [2:0]  SRC_REMOTE    = 3'h6;
    localparam logic [2:0]  SRC_SCHED     = 3'h7;

    // Request operations
    localparam logic [1:0]  OP_ARM        = 2'h1;
    localparam logic [1:0]  OP_DISARM     = 2'h2;
    localparam logic [1:0]  OP_ARM_ALL    = 2'h3;

    localparam logic [1:0]  PART_ALL_ZERO = 2'h0;
    localparam logic [1:0]  PART_ALL_ONE  = 2'h3;
    localparam logic [0:0]  LOBBY_RST     = 1'h1;

endpackage : salal_pkg

// ---- hdl/salal_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module salal_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } salal_sync_type;

    salal_sync_type st_r;
    salal_sync_type st_nxt;

    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = asyncIn;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // Only the agreeing later stages decide; first stage is left alone
        for (int i = 0; i < WIDTH; i++)
        begin
            if (st_r.s2[i] == st_r.s3[i])
            begin
                st_nxt.q[i] = st_r.s3[i];
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign syncOut = st_r.q;
endmodule : salal_sync

// ---- hdl/salal_cfg_check.sv ----
// Configuration validator for per-partition lobby flags
`timescale 1ns/1ps
module salal_cfg_check #(
    parameter int PARTS = 2
) (
    input  wire logic [PARTS-1:0] couplesReq,
    input  wire logic [PARTS-1:0] armsReq,
    output logic      [PARTS-1:0] armsOk,
    output logic                  cfgBad
);
    // Arming flag without coupling flag is an illegal entry
    genvar g;
    generate
        for (g = 0; g < PARTS; g++)
        begin : gChk
            assign armsOk[g] = armsReq[g] & couplesReq[g];
        end
    endgenerate

    assign cfgBad = |(armsReq & ~couplesReq);
endmodule : salal_cfg_check

// ---- hdl/salal_lobby.sv ----
// Shared lobby arming coordinator top level
//
// Contract
// - One partition is designated the lobby
// - First coupled disarm also disarms lobby
// - Refuse lobby arm while coupled disarmed
// - Coupled-only last arm: no auto attempt
// - Lobby-arming partition armed: attempt lobby arm
// - Attempt fails on lobby fault or disarm
// - Reject lobby-arming flag without coupling flag
// - Global code suppresses automatic lobby following
// - Global arm-all still refuses, raises failure
// - Non-global code follows flags normally
// - Quick, keyswitch, wireless keep following active
// - Remote session commands never make lobby follow
// - Scheduled commands never make lobby follow
// - Cross-partition logon only when target enabled
`timescale 1ns/1ps
module salal_lobby
    import salal_pkg::*;
#(
    parameter int PARTS = salal_pkg::PART_NUM
) (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    // Installer configuration
    input  wire logic [salal_pkg::PART_IDX_W-1:0] lobbyPartSel,
    input  wire logic [PARTS-1:0]              couplesLobbyCfg,
    input  wire logic [PARTS-1:0]              armsLobbyCfg,
    input  wire logic [PARTS-1:0]              cross_partition_logon_enable,
    // Arm and disarm request, one-cycle strobe
    input  wire logic                          reqValid,
    input  wire logic [salal_pkg::OP_W-1:0]    reqOp,
    input  wire logic [salal_pkg::SRC_W-1:0]   reqSrc,
    input  wire logic [PARTS-1:0]              reqParts,
    // Keypad logon request, one-cycle strobe
    input  wire logic                          logonValid,
    input  wire logic [salal_pkg::PART_IDX_W-1:0] logonTarget,
    input  wire logic                          logonMultiAccess,
    // Zone fault levels, asynchronous
    input  wire logic [PARTS-1:0]              partFaultAsync,
    // Status
    output logic      [PARTS-1:0]              armedState,
    output logic                               lobby_arm_failed_indication,
    output logic                               cfgRejected,
    output logic                               logonGranted,
    output logic                               logonDenied,
    output logic                               reqDone
);
    import salal_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PARTS-1:0] armed;
        logic             failInd;
        logic             cfgRej;
        logic             logonOk;
        logic             logonNo;
        logic             done;
    } salal_state_type;

    salal_state_type st_r;
    salal_state_type st_nxt;

    logic [PARTS-1:0] faultSync;
    logic [PARTS-1:0] armsOk;
    logic             cfgBad;

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    salal_sync #(
        .WIDTH (PARTS)
    ) uSync (
        .mclk    (mclk),
        .rst     (rst),
        .asyncIn (partFaultAsync),
        .syncOut (faultSync)
    );

    salal_cfg_check #(
        .PARTS (PARTS)
    ) uCfg (
        .couplesReq (couplesLobbyCfg),
        .armsReq    (armsLobbyCfg),
        .armsOk     (armsOk),
        .cfgBad     (cfgBad)
    );

    // ------------------------------------------------------------
    // Decision logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic [PARTS-1:0] lobbyMask;
        logic [PARTS-1:0] coupled;
        logic [PARTS-1:0] armTgt;
        logic [PARTS-1:0] disTgt;
        logic [PARTS-1:0] armedAfter;
        logic             follow;
        logic             lobbyArmReq;
        logic             autoTry;
        logic             lobbyBlocked;
        logic             anyCoupledDisarmedBefore;
        logic             disarmsCoupled;

        lobbyMask   = '0;
        lobbyMask[lobbyPartSel] = 1'b1;
        // Lobby never couples to itself
        coupled     = couplesLobbyCfg & ~lobbyMask;
        armTgt      = '0;
        disTgt      = '0;
        armedAfter  = st_r.armed;
        lobbyArmReq = 1'b0;
        autoTry     = 1'b0;
        disarmsCoupled = 1'b0;
        lobbyBlocked   = 1'b0;
        anyCoupledDisarmedBefore = |(coupled & ~st_r.armed);

        st_nxt         = st_r;
        st_nxt.done    = 1'b0;
        st_nxt.logonOk = 1'b0;
        st_nxt.logonNo = 1'b0;
        st_nxt.cfgRej  = cfgBad;

        // Remote, scheduled and global operations do not follow
        follow = (reqSrc != SRC_REMOTE) && (reqSrc != SRC_SCHED)
                 && (reqSrc != SRC_GLOBAL);

        if (reqValid)
        begin
            st_nxt.done = 1'b1;
            unique case (reqOp)
                OP_ARM, OP_ARM_ALL:
                begin
                    armTgt      = reqParts & ~lobbyMask;
                    lobbyArmReq = |(reqParts & lobbyMask);
                end
                OP_DISARM:
                begin
                    disTgt = reqParts;
                end
                default:
                begin
                end
            endcase
            armedAfter = (st_r.armed | armTgt) & ~disTgt;

            // First coupled disarm drops the lobby too
            disarmsCoupled = |(disTgt & coupled & st_r.armed);
            if (follow && disarmsCoupled && !anyCoupledDisarmedBefore)
            begin
                armedAfter = armedAfter & ~lobbyMask;
            end

            // Auto attempt only from a newly armed lobby-arming partition
            autoTry = follow && |(armTgt & armsOk & ~st_r.armed);

            lobbyBlocked = |(coupled & ~armedAfter) || |(faultSync & lobbyMask);
            if (lobbyArmReq || autoTry)
            begin
                if (lobbyBlocked)
                begin
                    st_nxt.failInd = 1'b1;
                end
                else
                begin
                    armedAfter     = armedAfter | lobbyMask;
                    st_nxt.failInd = 1'b0;
                end
            end
            st_nxt.armed = armedAfter;
        end

        if (logonValid)
        begin
            if (logonMultiAccess && cross_partition_logon_enable[logonTarget])
            begin
                st_nxt.logonOk = 1'b1;
            end
            else
            begin
                st_nxt.logonNo = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign armedState                  = st_r.armed;
    assign lobby_arm_failed_indication = st_r.failInd;
    assign cfgRejected                 = st_r.cfgRej;
    assign logonGranted                = st_r.logonOk;
    assign logonDenied                 = st_r.logonNo;
    assign reqDone                     = st_r.done;
endmodule : salal_lobby

// ---- testbench/salal_lobby_asserts.sv ----
// Checker for the lobby arming coordinator
`timescale 1ns/1ps
module salal_lobby_chk #(
    parameter int PARTS = salal_pkg::PART_NUM
) (
    input wire logic [0:0]             mclk,
    input wire logic [0:0]             rst,
    input wire logic [salal_pkg::PART_IDX_W-1:0] lobbyPartSel,
    input wire logic [PARTS-1:0]       couplesLobbyCfg,
    input wire logic [PARTS-1:0]       armsLobbyCfg,
    input wire logic [0:0]             reqValid,
    input wire logic [salal_pkg::OP_W-1:0] reqOp,
    input wire logic [salal_pkg::SRC_W-1:0] reqSrc,
    input wire logic [PARTS-1:0]       reqParts,
    input wire logic [PARTS-1:0]       armedState,
    input wire logic [0:0]             lobby_arm_failed_indication,
    input wire logic [0:0]             cfgRejected,
    input wire logic [0:0]             reqDone
);
    import salal_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic o, fol, lobA;
    assign o    = ~lobbyPartSel[0];
    assign fol  = !(reqSrc inside {SRC_GLOBAL, SRC_REMOTE, SRC_SCHED});
    assign lobA = armedState[lobbyPartSel];
    a_done_step: assert property (reqDone == $past(reqValid))
        else $error("done out of step");
    a_cfg_reject: assert property (
        cfgRejected == $past(|(armsLobbyCfg & ~couplesLobbyCfg))) else $error("bad reject");
    a_idle_hold: assert property (!reqValid |=> $stable(armedState))
        else $error("state moved while idle");
    a_lobby_refuse: assert property (
        reqValid && reqOp[0] && reqParts[lobbyPartSel] && !reqParts[o] && couplesLobbyCfg[o]
        && !armedState[o] |=> $stable(lobA) && lobby_arm_failed_indication)
        else $error("lobby armed");
    a_no_follow: assert property (
        reqValid && !reqParts[lobbyPartSel] && (!fol || reqOp == OP_ARM && !armsLobbyCfg[o])
        |=> $stable(lobA)) else $error("lobby followed");
    a_follow_off: assert property (
        reqValid && reqOp == OP_DISARM && fol && reqParts[o] && couplesLobbyCfg[o]
        && armedState[o] |=> !lobA) else $error("lobby kept armed");
    a_follow_on: assert property (
        reqValid && reqOp == OP_ARM && fol && reqParts[o] && couplesLobbyCfg[o]
        && armsLobbyCfg[o] && !armedState[o] |=> lobA || lobby_arm_failed_indication)
        else $error("no lobby attempt");
    a_fail_clear: assert property ($rose(lobA) |-> !lobby_arm_failed_indication)
        else $error("failure kept after arming");
endmodule : salal_lobby_chk

bind salal_lobby salal_lobby_chk #(.PARTS(PARTS)) u_chk (.*);

// ---- testbench/salal_user.sv ----
// Model of the users issuing arm and disarm requests
`timescale 1ns/1ps
module salal_user (
    input  wire logic                       mclk,
    output logic [0:0]                      reqValid,
    output logic [salal_pkg::OP_W-1:0]      reqOp,
    output logic [salal_pkg::SRC_W-1:0]     reqSrc,
    output logic [salal_pkg::PART_NUM-1:0]  reqParts
);
    import salal_pkg::*;
    initial
    begin
        reqValid = 1'h0;
        reqOp    = 2'h0;
        reqSrc   = 3'h0;
        reqParts = 2'h0;
    end
    // Idle fields inverted so stale values are never trusted
    task automatic send(input logic [1:0] op, input logic [2:0] src, input logic [1:0] p);
        @(posedge mclk);
        reqValid <= 1'h1;
        reqOp    <= op;
        reqSrc   <= src;
        reqParts <= p;
        @(posedge mclk);
        reqValid <= 1'h0;
        reqOp    <= ~op;
        reqSrc   <= ~src;
        reqParts <= ~p;
        repeat ($urandom % 3) @(posedge mclk);
    endtask : send
endmodule : salal_user

// ---- testbench/salal_lobby_tb_top.sv ----
// Self-checking bench for the lobby arming coordinator
`timescale 1ns/1ps
module salal_lobby_tb_top;
    import salal_pkg::*;
    logic       mclk, rst, reqValid, logonValid, logonTarget, logonMultiAccess, expF, g;
    logic       lobby_arm_failed_indication, cfgRejected, logonGranted, logonDenied, reqDone;
    logic       lobbyPartSel;
    logic [1:0] couplesLobbyCfg, armsLobbyCfg, cross_partition_logon_enable, reqOp, expA;
    logic [1:0] reqParts, partFaultAsync, armedState;
    logic [2:0] reqSrc;
    logic [3:0] expQ[$];
    logic [1:0] logQ[$];
    int         mismatches, check_count;

    salal_lobby DUT (.*);
    salal_user  U (.*);

    initial
    begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    // Lobby is index 1, other partition 0
    task automatic req(input logic [1:0] op, input logic [2:0] src, input logic [1:0] p);
        logic       fol;
        logic       tryL;
        logic [1:0] m;
        m   = p;
        fol = !(src inside {SRC_GLOBAL, SRC_REMOTE, SRC_SCHED});
        if (op == OP_DISARM)
        begin
            m[1] = m[1] | fol & m[0] & couplesLobbyCfg[0] & expA[0];
            expA = expA & ~m;
        end
        else
        begin
            tryL    = m[1] | fol & m[0] & ~expA[0] & couplesLobbyCfg[0] & armsLobbyCfg[0];
            expA[0] = expA[0] | m[0];
            if (tryL && (partFaultAsync[1] || couplesLobbyCfg[0] && !expA[0]))
                expF = 1'h1;
            else if (tryL)
                {expA[1], expF} = 2'h2;
        end
        expQ.push_back({1'h0, expA, expF});
        U.send(op, src, p);
    endtask : req

    always @(posedge mclk)
        if (reqDone === 1'h1)
            chk({1'h0, armedState, lobby_arm_failed_indication},
                expQ.size() > 0 ? expQ.pop_front() : 4'hF);

    always @(posedge mclk)
        if (logonGranted === 1'h1 || logonDenied === 1'h1)
            chk({2'h0, logonGranted, logonDenied},
                logQ.size() > 0 ? {2'h0, logQ.pop_front()} : 4'hF);

    initial
    begin
        #200000;
        mismatches++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        mismatches = 0;
        check_count = 0;
        expA = 2'h0;
        expF = 1'h0;
        rst = 1'h1;
        lobbyPartSel = 1'h1;
        couplesLobbyCfg = 2'h0;
        armsLobbyCfg = 2'h0;
        cross_partition_logon_enable = 2'h0;
        logonValid = 1'h0;
        logonTarget = 1'h0;
        logonMultiAccess = 1'h0;
        partFaultAsync = 2'h0;
        void'($urandom(21719));
        repeat (8) @(posedge mclk);
        rst <= 1'h0;
        repeat (4) @(posedge mclk);
        for (int k = 0; k < 4; k++)
        begin
            couplesLobbyCfg <= {1'h0, k[0]};
            armsLobbyCfg <= {1'h0, k[1]};
            repeat (2) @(posedge mclk);
            chk({3'h0, cfgRejected}, {3'h0, k == 2});
            for (int i = 0; i < 24; i++)
                req($urandom % 2 ? OP_ARM : OP_DISARM, i[2:0], 2'($urandom % 3 + 1));
        end
        partFaultAsync <= 2'h2;
        repeat (6) @(posedge mclk);
        req(OP_DISARM, SRC_KEYPAD, 2'h3);
        req(OP_ARM, SRC_WLKPD, 2'h1);
        partFaultAsync <= 2'h0;
        repeat (6) @(posedge mclk);
        req(OP_DISARM, SRC_REMOTE, 2'h1);
        req(OP_ARM_ALL, SRC_GLOBAL, 2'h2);
        // Scheduled arming: coupled partition first, lobby armed last
        req(OP_ARM, SRC_SCHED, 2'h1);
        req(OP_ARM, SRC_SCHED, 2'h2);
        for (int i = 0; i < 16; i++)
        begin
            cross_partition_logon_enable <= i[1:0];
            logonTarget <= i[2];
            logonMultiAccess <= i[3];
            logonValid <= 1'h1;
            g = i[3] && i[i[2]];
            logQ.push_back({g, !g});
            @(posedge mclk);
            logonValid <= 1'h0;
            @(posedge mclk);
        end
        repeat (4) @(posedge mclk);
        chk(4'(expQ.size()), 4'h0);
        chk(4'(logQ.size()), 4'h0);
        tally_and_finish();
    end
endmodule : salal_lobby_tb_top
